// File: design/dsos_consts.svh
`ifndef DSOS_CONSTS_SVH
`define DSOS_CONSTS_SVH
`define DSOS_CLK_HZ          10000000
`define DSOS_HOLD_MS         500
`define DSOS_HOLD_CYC        ((`DSOS_CLK_HZ / 1000) * `DSOS_HOLD_MS)
`define DSOS_STOP_FREQ_DHZ   16'h0005
`define DSOS_AT_SPEED_DHZ    16'h001e
`define DSOS_LOOP_LOSS_UA    16'h07d0
`define DSOS_RESTART_LIMIT   3'h5
`define DSOS_SYNC_RESET      2'h0
`define DSOS_ADDR_CTRL       4'h0
`define DSOS_ADDR_OUTSEL     4'h1
`define DSOS_ADDR_PRESET3    4'h2
`define DSOS_ADDR_PRESET4    4'h3
`define DSOS_ADDR_MINSPD     4'h4
`define DSOS_ADDR_LOWLIM     4'h5
`define DSOS_ADDR_HIGHLIM    4'h6
`define DSOS_ADDR_STATUS     4'h7
`define DSOS_ADDR_SPEEDREF   4'h8
`define DSOS_CTRL_RESET      32'h0000_0000
`define DSOS_OUTSEL_RESET    32'h0000_0000
`define DSOS_CTRL_CFI_LSB    0
`define DSOS_CTRL_LOSS_LSB   2
`define DSOS_CTRL_LOOP_BIT   4
`define DSOS_CTRL_PID_BIT    5
`endif

// File: design/dsos_pkg.sv
package dsos_pkg;
    typedef enum logic [1:0] {
        DSOS_TRIP_ON_CLOSE  = 2'h0,
        DSOS_TRIP_ON_OPEN   = 2'h1,
        DSOS_CLEAR_ON_CLOSE = 2'h2,
        DSOS_CFI_SPARE      = 2'h3
    } dsos_cfi_e;
    typedef enum logic [1:0] {
        DSOS_LOSS_MIN_SPEED = 2'h0,
        DSOS_LOSS_FAULT     = 2'h1,
        DSOS_LOSS_PRESET4   = 2'h2,
        DSOS_LOSS_SPARE     = 2'h3
    } dsos_loss_e;
    typedef enum logic [3:0] {
        DSOS_SEL_NONE       = 4'h0,
        DSOS_SEL_RUN        = 4'h1,
        DSOS_SEL_HEALTHY    = 4'h2,
        DSOS_SEL_INV_FAULT  = 4'h3,
        DSOS_SEL_LOCKOUT    = 4'h4,
        DSOS_SEL_AT_SPEED   = 4'h5,
        DSOS_SEL_ABOVE_P3   = 4'h6,
        DSOS_SEL_CUR_LIMIT  = 4'h7,
        DSOS_SEL_AUTO_MAN   = 4'h8,
        DSOS_SEL_LOOP_PRES  = 4'h9,
        DSOS_SEL_WINDOW     = 4'ha,
        DSOS_SEL_WINDOW_INV = 4'hb,
        DSOS_SEL_LOW        = 4'hc,
        DSOS_SEL_LOW_INV    = 4'hd,
        DSOS_SEL_HIGH       = 4'he,
        DSOS_SEL_HIGH_INV   = 4'hf
    } dsos_sel_e;
    typedef enum logic [1:0] {
        DSOS_BUS_IDLE = 2'h0,
        DSOS_BUS_ACK  = 2'h1,
        DSOS_BUS_DONE = 2'h2
    } dsos_bus_e;
endpackage : dsos_pkg

// File: design/dsos_out_sel.sv
`timescale 1ns/1ps
`include "dsos_consts.svh"
module dsos_out_sel
    import dsos_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [3:0]  sel,
    input  wire logic [15:0] ind,
    output logic             out_q
);
    // ind bit n is the indication for selection code n; bit 0 is none and tied low
    logic out_d;
    assign out_d = (sel == DSOS_SEL_NONE) ? 1'b0 : ind[sel];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) out_q <= 1'b0;
        else        out_q <= out_d;
    end
endmodule : dsos_out_sel

// File: design/dsos_top.sv
`timescale 1ns/1ps
`include "dsos_consts.svh"
module dsos_top
    import dsos_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    // terminal pins, all asynchronous
    input  wire logic        config_fault_input_pin,
    input  wire logic        remote_stop_input,
    input  wire logic        keypad_stop,
    input  wire logic        start_cmd,
    input  wire logic        trip_event,
    input  wire logic        restart_failed,
    input  wire logic        current_limit,
    input  wire logic        auto_mode,
    input  wire logic        reverse_sel,
    // drive state from same-clock logic
    input  wire logic [15:0] out_freq_dhz,
    input  wire logic [15:0] speed_setpoint_dhz,
    input  wire logic [15:0] speed_ref,
    input  wire logic [15:0] process_feedback,
    input  wire logic [15:0] loop_current_ua,
    output logic             first_oc_out_q,
    output logic             second_oc_out_q,
    output logic             relay_out_q,
    output logic             fault_q,
    output logic             follower_fault_q,
    output logic             loss_speed_valid_q,
    output logic [15:0]      loss_speed_q
);
    // ---------- pin synchronisers ----------
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    assign pin_raw = {config_fault_input_pin, remote_stop_input, keypad_stop, start_cmd, trip_event,
                      restart_failed, current_limit, auto_mode, reverse_sel};
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end
    // config input high means closed to the common terminal
    wire cfi_closed = sync2_q[8];
    wire rstop      = sync2_q[7];
    wire kstop      = sync2_q[6];
    wire start_s    = sync2_q[5];
    wire trip_s     = sync2_q[4];
    wire rfail_s    = sync2_q[3];
    wire ilim_s     = sync2_q[2];
    wire auto_s     = sync2_q[1];
    wire rev_s      = sync2_q[0];

    // ---------- registers ----------
    logic [31:0] ctrl_q;
    logic [31:0] outsel_q;
    logic [15:0] preset3_q;
    logic [15:0] preset4_q;
    logic [15:0] minspd_q;
    logic [15:0] lowlim_q;
    logic [15:0] highlim_q;

    wire [1:0] cfi_mode  = ctrl_q[`DSOS_CTRL_CFI_LSB +: 2];
    wire [1:0] loss_act  = ctrl_q[`DSOS_CTRL_LOSS_LSB +: 2];
    wire       loop_rng  = ctrl_q[`DSOS_CTRL_LOOP_BIT];
    wire       pid_on    = ctrl_q[`DSOS_CTRL_PID_BIT];

    // bus: one wait state then acknowledge
    dsos_bus_e bus_q;
    dsos_bus_e bus_d;
    wire req     = avs_read | avs_write;
    wire at_ack  = (bus_q == DSOS_BUS_ACK);
    wire wr_take = at_ack & avs_write;
    wire mapped  = (avs_address <= `DSOS_ADDR_SPEEDREF);
    assign bus_d = (bus_q == DSOS_BUS_IDLE && req) ? DSOS_BUS_ACK :
                   at_ack ? DSOS_BUS_DONE : DSOS_BUS_IDLE;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    wire [31:0] wmerge_ctrl = merge(ctrl_q, avs_writedata, avs_byteenable);
    wire [31:0] wmerge_sel  = merge(outsel_q, avs_writedata, avs_byteenable);
    wire [31:0] wmerge_p3   = merge({16'h0000, preset3_q}, avs_writedata, avs_byteenable);
    wire [31:0] wmerge_p4   = merge({16'h0000, preset4_q}, avs_writedata, avs_byteenable);
    wire [31:0] wmerge_min  = merge({16'h0000, minspd_q}, avs_writedata, avs_byteenable);
    wire [31:0] wmerge_low  = merge({16'h0000, lowlim_q}, avs_writedata, avs_byteenable);
    wire [31:0] wmerge_high = merge({16'h0000, highlim_q}, avs_writedata, avs_byteenable);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bus_q     <= DSOS_BUS_IDLE;
            ctrl_q    <= `DSOS_CTRL_RESET;
            outsel_q  <= `DSOS_OUTSEL_RESET;
            preset3_q <= 16'h0000;
            preset4_q <= 16'h0000;
            minspd_q  <= 16'h0000;
            lowlim_q  <= 16'h0000;
            highlim_q <= 16'hffff;
        end else begin
            bus_q <= bus_d;
            if (wr_take) begin
                if (avs_address == `DSOS_ADDR_CTRL)    ctrl_q    <= {26'h0, wmerge_ctrl[5:0]};
                if (avs_address == `DSOS_ADDR_OUTSEL)  outsel_q  <= {20'h0, wmerge_sel[11:0]};
                if (avs_address == `DSOS_ADDR_PRESET3) preset3_q <= wmerge_p3[15:0];
                if (avs_address == `DSOS_ADDR_PRESET4) preset4_q <= wmerge_p4[15:0];
                if (avs_address == `DSOS_ADDR_MINSPD)  minspd_q  <= wmerge_min[15:0];
                if (avs_address == `DSOS_ADDR_LOWLIM)  lowlim_q  <= wmerge_low[15:0];
                if (avs_address == `DSOS_ADDR_HIGHLIM) highlim_q <= wmerge_high[15:0];
            end
        end
    end

    // ---------- fault engine ----------
    logic ext_trip;
    logic clear_req;
    logic loop_lost;
    logic any_trip;
    assign ext_trip  = (cfi_mode == DSOS_TRIP_ON_CLOSE && cfi_closed)
                     | (cfi_mode == DSOS_TRIP_ON_OPEN && !cfi_closed);
    // in clear mode the remote stop is disregarded; keypad stop always clears
    assign clear_req = kstop
                     | ((cfi_mode == DSOS_CLEAR_ON_CLOSE) ? cfi_closed : rstop);
    assign loop_lost = loop_rng & (loop_current_ua < `DSOS_LOOP_LOSS_UA);
    assign any_trip  = ext_trip | trip_s | (loop_lost && loss_act == DSOS_LOSS_FAULT);

    logic       fault_d;
    logic       ffault_d;
    logic [2:0] restarts_q;
    logic       lockout_q;
    logic       running_q;
    // a trip in the same cycle as a clear keeps the fault set
    assign fault_d  = any_trip | (fault_q & ~clear_req);
    assign ffault_d = (loop_lost && loss_act == DSOS_LOSS_FAULT) | (follower_fault_q & ~clear_req);

    // a stop is remembered until the ramp reaches the stop frequency, the stop input may be a short pulse
    logic stopping_q;
    logic rfail_prev_q;
    wire stop_stop = rstop | kstop;
    wire stop_seen = stop_stop | stopping_q;
    wire run_d = (start_s & ~any_trip) | (running_q & ~any_trip & ~fault_q
                 & ~(stop_seen & (out_freq_dhz <= `DSOS_STOP_FREQ_DHZ)));
    wire stopping_d = run_d & stop_seen & ~start_s;
    // count each failed restart once however long its pulse lasts
    wire rfail_edge = rfail_s & ~rfail_prev_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fault_q          <= 1'b0;
            follower_fault_q <= 1'b0;
            restarts_q       <= 3'h0;
            lockout_q        <= 1'b0;
            running_q        <= 1'b0;
            stopping_q       <= 1'b0;
            rfail_prev_q     <= 1'b0;
        end else begin
            fault_q          <= fault_d;
            follower_fault_q <= ffault_d;
            running_q        <= run_d;
            stopping_q       <= stopping_d;
            rfail_prev_q     <= rfail_s;
            if (!fault_q && !fault_d) restarts_q <= 3'h0;
            else if (rfail_edge && restarts_q != `DSOS_RESTART_LIMIT) restarts_q <= restarts_q + 3'h1;
            if (restarts_q == `DSOS_RESTART_LIMIT) lockout_q <= 1'b1;
            else if (!fault_q) lockout_q <= 1'b0;
        end
    end

    // loss action speed command
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            loss_speed_valid_q <= 1'b0;
            loss_speed_q       <= 16'h0000;
        end else begin
            loss_speed_valid_q <= loop_lost && (loss_act == DSOS_LOSS_MIN_SPEED || loss_act == DSOS_LOSS_PRESET4);
            loss_speed_q       <= (loss_act == DSOS_LOSS_PRESET4) ? preset4_q : minspd_q;
        end
    end

    // ---------- indications ----------
    // at speed: enter on reaching setpoint, hold within the band to stop chatter
    logic at_speed_q;
    wire [16:0] diff = (out_freq_dhz >= speed_setpoint_dhz) ? {1'b0, out_freq_dhz - speed_setpoint_dhz}
                                                            : {1'b0, speed_setpoint_dhz - out_freq_dhz};
    wire in_band = (diff <= {1'b0, `DSOS_AT_SPEED_DHZ});
    wire reached = (out_freq_dhz == speed_setpoint_dhz);

    // current limit stretched by a minimum hold
    localparam int HOLD = `DSOS_HOLD_CYC;
    logic [22:0] hold_cnt_q;
    logic        ilim_ind_q;
    wire hold_done = (hold_cnt_q == 23'h0);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            at_speed_q <= 1'b0;
            hold_cnt_q <= 23'h0;
            ilim_ind_q <= 1'b0;
        end else begin
            at_speed_q <= reached | (at_speed_q & in_band);
            if (!ilim_ind_q && ilim_s) begin
                ilim_ind_q <= 1'b1;
                hold_cnt_q <= 23'(HOLD - 1);
            end else if (ilim_ind_q && !hold_done) begin
                hold_cnt_q <= hold_cnt_q - 23'h1;
            end else if (ilim_ind_q && !ilim_s) begin
                ilim_ind_q <= 1'b0;
            end
        end
    end

    wire [15:0] mon   = pid_on ? process_feedback : speed_ref;
    wire        low_a = (mon < lowlim_q);
    wire        hi_a  = (mon > highlim_q);
    wire        win_a = low_a | hi_a;

    logic [15:0] ind;
    assign ind = {~hi_a,                                 // f
                  hi_a,                                  // e
                  ~low_a,                                // d
                  low_a,                                 // c
                  ~win_a,                                // b
                  win_a,                                 // a
                  loop_current_ua > `DSOS_LOOP_LOSS_UA,  // 9
                  auto_s,                                // 8
                  ilim_ind_q,                            // 7
                  out_freq_dhz > preset3_q,              // 6
                  at_speed_q,                            // 5
                  ~lockout_q,                            // 4
                  fault_q,                               // 3
                  ~fault_q,                              // 2
                  running_q,                             // 1
                  1'b0};                                 // 0
    // direction has no selection code: reverse_sel reaches only the status register
    // ind_dir is ind unchanged for all three outputs
    wire [15:0] ind_dir = ind;

    dsos_out_sel u_first (
        .clock (clock),
        .rst_b (rst_b),
        .sel   (outsel_q[3:0]),
        .ind   (ind_dir),
        .out_q (first_oc_out_q)
    );
    dsos_out_sel u_second (
        .clock (clock),
        .rst_b (rst_b),
        .sel   (outsel_q[7:4]),
        .ind   (ind_dir),
        .out_q (second_oc_out_q)
    );

    // relay output: selection high nibble; outsel keeps only bits 11:0, so no bit selects a reverse indication
    logic relay_base;
    assign relay_base = 1'b0;
    dsos_out_sel u_relay (
        .clock (clock),
        .rst_b (rst_b),
        .sel   (outsel_q[11:8]),
        .ind   (ind_dir),
        .out_q (relay_out_q)
    );

    // ---------- bus read ----------
    wire [31:0] status = {24'h0, rev_s, loop_lost, lockout_q, ilim_ind_q, at_speed_q,
                          running_q, follower_fault_q, fault_q};
    wire [31:0] rmux =
        (avs_address == `DSOS_ADDR_CTRL)     ? ctrl_q :
        (avs_address == `DSOS_ADDR_OUTSEL)   ? outsel_q :
        (avs_address == `DSOS_ADDR_PRESET3)  ? {16'h0, preset3_q} :
        (avs_address == `DSOS_ADDR_PRESET4)  ? {16'h0, preset4_q} :
        (avs_address == `DSOS_ADDR_MINSPD)   ? {16'h0, minspd_q} :
        (avs_address == `DSOS_ADDR_LOWLIM)   ? {16'h0, lowlim_q} :
        (avs_address == `DSOS_ADDR_HIGHLIM)  ? {16'h0, highlim_q} :
        (avs_address == `DSOS_ADDR_STATUS)   ? status :
        (avs_address == `DSOS_ADDR_SPEEDREF) ? {15'h0, relay_base, mon} : 32'h0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata    <= 32'h0;
            avs_waitrequest <= 1'b1;
            avs_response    <= 2'h0;
        end else begin
            avs_waitrequest <= ~(bus_q == DSOS_BUS_IDLE && req);
            avs_readdata    <= (bus_q == DSOS_BUS_IDLE && avs_read) ? rmux : 32'h0;
            avs_response    <= (bus_q == DSOS_BUS_IDLE && req && !mapped) ? 2'h2 : 2'h0;
        end
    end
endmodule : dsos_top

// File: testbench/dsos_field.sv
`timescale 1ns/1ps
module dsos_field (
    input  wire logic       clock,
    input  wire logic       contact_closed,
    input  wire logic [2:0] coil_drive,
    output logic            config_fault_input_pin,
    output logic [2:0]      load_on
);
    // dry contact to common: closed reads high, changes only after a clock edge
    initial config_fault_input_pin = 1'b0;
    always @(posedge clock) config_fault_input_pin <= contact_closed;
    // sinks and relay coil just follow the drive, a load cannot latch anything
    assign load_on = coil_drive;
endmodule : dsos_field

// File: testbench/dsos_top_chk.sv
`timescale 1ns/1ps
module dsos_top_chk (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        config_fault_input_pin,
    input wire logic        auto_mode,
    input wire logic [15:0] loop_current_ua,
    input wire logic        first_oc_out_q,
    input wire logic        fault_q,
    input wire logic        follower_fault_q
);
    // shadows from accepted writes; full byte lanes assumed, partial writes would mislead them
    logic [5:0] ctrl_q;
    logic [3:0] sel_q;
    wire        wr_ok = avs_write && !avs_waitrequest;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= 6'h00;
            sel_q  <= 4'h0;
        end else if (wr_ok && avs_address == 4'h0) begin
            ctrl_q <= avs_writedata[5:0];
        end else if (wr_ok && avs_address == 4'h1) begin
            sel_q <= avs_writedata[3:0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    chk_none_idle: assert property ((sel_q == 4'h0)[*2] |-> !first_oc_out_q) else $error("none lit");
    chk_trip_close: assert property (
        (ctrl_q[1:0] == 2'h0 && config_fault_input_pin)[*4] |-> fault_q) else $error("no trip on close");
    chk_trip_open: assert property (
        (ctrl_q[1:0] == 2'h1 && !config_fault_input_pin)[*4] |-> fault_q) else $error("no trip on open");
    chk_inv_fault: assert property (
        (sel_q == 4'h3 && $stable(fault_q))[*3] |-> first_oc_out_q == fault_q) else $error("inverse fault");
    chk_auto_mode: assert property (
        (sel_q == 4'h8 && $stable(auto_mode))[*4] |-> first_oc_out_q == auto_mode) else $error("auto mode");
    chk_ilim_hold: assert property (
        $rose(first_oc_out_q) && sel_q == 4'h7 |=> (first_oc_out_q || sel_q != 4'h7)[*8]) else $error("hold");
    chk_loop_present: assert property (
        sel_q == 4'h9 && $past(sel_q) == 4'h9 && $past(loop_current_ua) > 16'h07d0 |-> first_oc_out_q)
        else $error("loop present");
    chk_loss_fault: assert property (
        (ctrl_q[4:2] == 3'h5 && loop_current_ua < 16'h07d0)[*2] |-> follower_fault_q) else $error("loss");
endmodule : dsos_top_chk

// File: testbench/test_drive_status_output_select.sv
`timescale 1ns/1ps
module test_drive_status_output_select;
    localparam int RS = 0, KS = 1, TR = 2, RF = 3, CL = 4, ST = 5;
    logic        clock, rst_b, avs_read, avs_write, avs_waitrequest, contact_closed, auto_mode, reverse_sel;
    logic        fault_q, follower_fault_q, loss_speed_valid_q, config_fault_input_pin;
    logic        first_oc_out_q, second_oc_out_q, relay_out_q;
    logic [5:0]  ev;
    logic [2:0]  load_on;
    logic [1:0]  avs_response;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] out_freq_dhz, speed_setpoint_dhz, speed_ref, process_feedback, loop_current_ua, loss_speed_q;
    logic [15:0] v [4] = '{16'd99, 16'd100, 16'd300, 16'd301};
    int          errors, cmp_count;
    wire         oc1 = first_oc_out_q;
    dsos_top i_dut (.clock, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .avs_response, .config_fault_input_pin, .remote_stop_input(ev[RS]),
        .keypad_stop(ev[KS]), .start_cmd(ev[ST]), .trip_event(ev[TR]), .restart_failed(ev[RF]),
        .current_limit(ev[CL]), .auto_mode, .reverse_sel, .out_freq_dhz, .speed_setpoint_dhz, .speed_ref,
        .process_feedback, .loop_current_ua, .first_oc_out_q, .second_oc_out_q, .relay_out_q, .fault_q,
        .follower_fault_q, .loss_speed_valid_q, .loss_speed_q);
    dsos_field i_field (.clock, .contact_closed, .config_fault_input_pin, .load_on,
        .coil_drive({relay_out_q, second_oc_out_q, first_oc_out_q}));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
        @(posedge clock);
        for (n = 0; avs_waitrequest !== 1'b0 && n < 40; n++) @(posedge clock);
        rd = avs_readdata;
        if (n < 40) begin
            {avs_write, avs_read} <= 2'b00;
        end else begin
            errors++;
            final_report();
        end
    endtask : bus
    // pulses stay long enough to pass the two-flop synchronisers
    task automatic pulse(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        wt(4);
        ev[i] <= 1'b0;
        wt(8);
    endtask : pulse
    task automatic contact(input logic c);
        contact_closed <= c;
        wt(8);
    endtask : contact
    function automatic logic alarm(input int s, input logic [15:0] x);
        alarm = (s < 12 ? (x < 16'd100 || x > 16'd300) : s < 14 ? x < 16'd100 : x > 16'd300) ^ s[0];
    endfunction : alarm
    initial begin
        errors = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        {avs_read, avs_write, contact_closed, auto_mode, reverse_sel, ev} = '0;
        {avs_address, avs_byteenable, avs_writedata} = {4'h0, 4'hf, 32'h0};
        {out_freq_dhz, speed_setpoint_dhz, speed_ref, process_feedback} = '0;
        loop_current_ua = 16'h0fa0;
        wt(8);
        rst_b <= 1'b1;
        bus(0, 4'h6, 0);
        chk(rd, 32'h0000_ffff);
        bus(0, 4'h9, 0);
        chk({rd[29:0], avs_response}, 32'h2);
        auto_mode <= 1'b1;
        pulse(CL);
        chk(load_on, 3'b000);
        bus(1, 4'h1, 32'h23);
        contact(1'b1);
        chk({fault_q, load_on}, 4'b1001);
        contact(1'b0);
        bus(1, 4'h0, 32'h2);
        pulse(RS);
        chk(fault_q, 1);
        contact(1'b1);
        chk({fault_q, load_on}, 4'b0010);
        contact(1'b0);
        pulse(TR);
        pulse(KS);
        chk(fault_q, 0);
        contact(1'b1);
        bus(1, 4'h0, 32'h1);
        wt(8);
        chk(fault_q, 0);
        contact(1'b0);
        chk(fault_q, 1);
        bus(1, 4'h0, 32'h2);
        contact(1'b1);
        chk(fault_q, 0);
        contact(1'b0);
        bus(1, 4'h0, 32'h0);
        bus(1, 4'h1, 32'h888);
        wt(6);
        chk(load_on, 3'b111);
        auto_mode <= 1'b0;
        wt(6);
        chk(load_on, 3'b000);
        bus(1, 4'h1, 32'h1);
        out_freq_dhz <= 16'd100;
        pulse(ST);
        pulse(KS);
        chk(oc1, 1);
        out_freq_dhz <= 16'd5;
        wt(6);
        chk(oc1, 0);
        bus(1, 4'h1, 32'h6);
        wt(4);
        chk(oc1, 1);
        bus(1, 4'h1, 32'h5);
        speed_setpoint_dhz <= 16'd5;
        wt(4);
        chk(oc1, 1);
        out_freq_dhz <= 16'd30;
        wt(4);
        chk(oc1, 1);
        out_freq_dhz <= 16'd40;
        wt(4);
        chk(oc1, 0);
        reverse_sel <= 1'b1;
        wt(4);
        bus(0, 4'h7, 0);
        chk(rd[7], 1);
        bus(1, 4'h5, 32'd100);
        bus(1, 4'h6, 32'd300);
        for (int s = 10; s < 16; s++) begin
            bus(1, 4'h1, s);
            for (int i = 0; i < 4; i++) begin
                speed_ref <= v[i];
                wt(4);
                chk(oc1, alarm(s, v[i]));
            end
        end
        process_feedback <= 16'd50;
        bus(1, 4'h0, 32'h20);
        wt(4);
        chk(oc1, 1);
        bus(1, 4'h3, 32'h123);
        bus(1, 4'h1, 32'h9);
        wt(4);
        chk(oc1, 1);
        loop_current_ua <= 16'd1500;
        bus(1, 4'h0, 32'h4);
        wt(4);
        chk({follower_fault_q, oc1}, 2'b00);
        bus(1, 4'h0, 32'h14);
        wt(4);
        chk(follower_fault_q, 1);
        bus(1, 4'h0, 32'h18);
        wt(4);
        chk({loss_speed_valid_q, loss_speed_q}, 17'h10123);
        loop_current_ua <= 16'h0fa0;
        bus(1, 4'h1, 32'h7);
        pulse(CL);
        wt(100);
        chk(oc1, 1);
        bus(1, 4'h1, 32'h4);
        pulse(TR);
        repeat (4) pulse(RF);
        chk(oc1, 1);
        pulse(RF);
        chk(oc1, 0);
        rst_b <= 1'b0;
        wt(2);
        chk({fault_q, load_on}, 4'b0000);
        rst_b <= 1'b1;
        wt(4);
        final_report();
    end
endmodule : test_drive_status_output_select
bind dsos_top dsos_top_chk i_chk (.clock, .rst_b, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest,
    .config_fault_input_pin, .auto_mode, .loop_current_ua, .first_oc_out_q, .fault_q, .follower_fault_q);
